// ==== lvl_pkg.sv ====
// constants, carrier structs and state types for the level switch control block
// assumes a 50 MHz clock and a synchronous, active-low reset at power-up
//
// Notes on behaviour
// - LED blinks when output off, steady when on
// - output follows wet/dry after fixed delay
// - dry-on setting closes output while dry
// - wet-on setting closes output while wetted
// - held button at power-up enters calibration
// - main menu cycles three options with flashes
// - brief press after an option enters it
// - switchpoint screen: one dark pulse, then on
// - press stores switchpoint, resets defaults, confirms
// - hysteresis screen: two dark pulses; press enters
// - hysteresis submenu cycles three levels, default two
// - press selects level, confirms, back to menu
// - LED-mode screen: three dark pulses; press enters
// - LED mode one shows output, two wetness
// - three-wire LED shows wetness with inversion pulses
// - fault flashes fast on three-wire and safety parts, test flashes slower
// - supply polarity selects N/C or N/O
// - safety variant opens on wet or fault
// - three-wire magnet inverts output after four seconds
// - NAMUR variant: steady when high current
package lvl_pkg;
   localparam int CLK_MHZ = 50;
   localparam int TICK_US = 1000;
   localparam int TICK_CYC = TICK_US * CLK_MHZ;

   // durations in milliseconds, counted in ticks
   localparam logic [11:0] DEB_MS = 12'h014;
   localparam logic [11:0] BOOT_MS = 12'h028;
   localparam logic [11:0] HOLD_ON_MS = 12'h3e8;
   localparam logic [11:0] HOLD_OFF_MS = 12'h7d0;
   localparam logic [11:0] LONG_MS = 12'h3e8;
   localparam logic [11:0] DELAY_MS = 12'h3e8;
   localparam logic [11:0] TEST_MS = 12'hfa0;
   localparam logic [11:0] FLASH_MS = 12'h096;
   localparam logic [11:0] GAP_MS = 12'h7d0;
   localparam logic [11:0] QUICK_MS = 12'h064;
   localparam logic [11:0] BLINK_HALF_MS = 12'h1f4;
   localparam logic [11:0] FAULT_HALF_MS = 12'h047;
   localparam logic [11:0] TEST_HALF_MS = 12'h0c8;

   localparam logic [1:0] HYST_DEF = 2'h2;
   localparam logic LMODE_DEF = 1'b0;
   localparam logic [1:0] OPT_SP = 2'h0;
   localparam logic [1:0] OPT_HYST = 2'h1;
   localparam logic [1:0] OPT_LED = 2'h2;

   typedef enum logic [6:0] {
      ST_BOOT = 7'h01,
      ST_HOLD = 7'h02,
      ST_RUN = 7'h04,
      ST_MAIN = 7'h08,
      ST_OPT = 7'h10,
      ST_SUB = 7'h20,
      ST_CONF = 7'h40
   } state_t;

   typedef enum logic [1:0] {
      V_TWO_WIRE = 2'h0,
      V_DC3 = 2'h1,
      V_SAFE = 2'h2,
      V_ISAFE = 2'h3
   } var_t;

   typedef struct packed {
      logic [11:0] code;
      logic fault;
   } sense_t;

   typedef struct packed {
      logic [11:0] sp;
      logic [1:0] hyst;
      logic lmode;
      logic cal;
   } settings_t;

   typedef struct packed {
      logic [11:0] cnt;
      logic clean;
   } deb_t;

   typedef struct packed {
      logic [15:0] tdiv;
      logic tick;
      state_t state;
      logic [11:0] ms;
      logic [3:0] slot;
      logic [11:0] sms;
      logic [1:0] item;
      logic [1:0] opt;
      logic [11:0] hold;
      logic btn_q;
      settings_t cfg;
      logic wet_raw;
      logic wet_dly;
      logic [11:0] dcnt;
      logic [11:0] tcnt;
      logic test_on;
      logic [11:0] bcnt;
      logic blink;
      logic out;
      logic led;
   } ctl_t;
endpackage

// ==== lvl_debounce.sv ====
// settle filter for a slow mechanical or magnetic input
// assumes raw is already synchronous and tick is a one-cycle millisecond pulse
`timescale 1ns/100ps
module lvl_debounce #(
   parameter logic [11:0] SETTLE = lvl_pkg::DEB_MS
) (
   input wire logic clk, // system clock
   input wire logic rst_n, // synchronous reset, active low
   input wire logic tick, // millisecond pulse
   input wire logic raw, // unfiltered input
   output logic clean // filtered level
);
   lvl_pkg::deb_t st;
   lvl_pkg::deb_t nxt;

   always_comb begin
      nxt = st;
      // any bounce back to the old level restarts the settle count
      if (raw == st.clean) begin
         nxt.cnt = '0;
      end else if (tick) begin
         if (st.cnt == SETTLE - 12'h001) begin
            nxt.clean = raw;
            nxt.cnt = '0;
         end else begin
            nxt.cnt = st.cnt + 12'h001;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= nxt;
      end
   end

   assign clean = st.clean;
endmodule

// ==== level_switch_ctl.sv ====
// switch output, status LED and calibration menu of a fork level switch
// assumes a debounced-free raw button and magnet, a sensed frequency code,
// and that power-up asserts rst_n; the menus are left only by power loss
`timescale 1ns/100ps
module level_switch_ctl #(
   parameter int TICK_CYCLES = lvl_pkg::TICK_CYC,
   parameter logic [11:0] SP_DEFAULT = 12'h800,
   parameter logic [11:0] HYST_STEP = 12'h010
) (
   input wire logic clk, // 50 MHz system clock
   input wire logic rst_n, // synchronous reset, active low
   input wire logic btn_raw, // setup button, high while pressed
   input wire logic magnet_raw, // test magnet present, high
   input wire logic nc_sel, // selector, polarity or wiring: high = N/C
   input wire lvl_pkg::var_t variant, // product variant strap
   input wire lvl_pkg::sense_t sense, // fork code and sensor fault
   output logic out_closed, // switched output, high = closed
   output logic led, // status LED, high = lit
   output lvl_pkg::settings_t settings // stored calibration settings
);
   lvl_pkg::ctl_t st;
   lvl_pkg::ctl_t nxt;
   logic btn_db;
   logic mag_db;
   logic [2:0] npul;
   logic pbase;
   logic [11:0] slen;
   logic gap;
   logic pulse;
   logic press;
   logic base;
   logic test_inv;
   logic [11:0] hp;
   logic [13:0] amt;
   logic [1:0] imax;

   lvl_debounce #(.SETTLE(lvl_pkg::DEB_MS)) u_btn (
      .clk(clk),
      .rst_n(rst_n),
      .tick(st.tick),
      .raw(btn_raw),
      .clean(btn_db)
   );

   lvl_debounce #(.SETTLE(lvl_pkg::DEB_MS)) u_mag (
      .clk(clk),
      .rst_n(rst_n),
      .tick(st.tick),
      .raw(magnet_raw),
      .clean(mag_db)
   );

   // flash pattern shape: npul pulses inverted from pbase, then a gap
   always_comb begin
      npul = 3'h1;
      pbase = 1'b0;
      imax = 2'h2;
      unique case (st.state)
         lvl_pkg::ST_MAIN: npul = {1'b0, st.item} + 3'h1;
         lvl_pkg::ST_SUB: begin
            npul = {1'b0, st.item} + 3'h1;
            if (st.opt == lvl_pkg::OPT_LED) begin
               imax = 2'h1;
            end
         end
         lvl_pkg::ST_OPT: begin
            npul = {1'b0, st.opt} + 3'h1;
            pbase = 1'b1;
         end
         lvl_pkg::ST_CONF: npul = 3'h3;
         lvl_pkg::ST_RUN: begin
            npul = st.out ? 3'h2 : 3'h1;
            pbase = st.wet_dly;
         end
         default: ;
      endcase
      // >= so a pulse count that shrinks mid-cycle still reaches the gap
      gap = st.slot >= {npul, 1'b0};
      pulse = !gap && !st.slot[0];
      if (st.state == lvl_pkg::ST_CONF) begin
         slen = lvl_pkg::QUICK_MS;
      end else if (gap) begin
         slen = lvl_pkg::GAP_MS;
      end else begin
         slen = lvl_pkg::FLASH_MS;
      end
      press = st.btn_q && !btn_db && (st.hold < lvl_pkg::LONG_MS);
   end

   // contact function per variant and the free blink period
   always_comb begin
      unique case (variant)
         lvl_pkg::V_TWO_WIRE: base = nc_sel ? !st.wet_dly : st.wet_dly;
         lvl_pkg::V_DC3: base = nc_sel ? !st.wet_dly : st.wet_dly;
         lvl_pkg::V_SAFE: base = !st.wet_dly && !sense.fault;
         lvl_pkg::V_ISAFE: base = nc_sel ? !st.wet_dly : st.wet_dly;
      endcase
      test_inv = (variant == lvl_pkg::V_DC3) && st.test_on;
      if (sense.fault && variant != lvl_pkg::V_TWO_WIRE) begin
         hp = lvl_pkg::FAULT_HALF_MS;
      end else if (test_inv) begin
         hp = lvl_pkg::TEST_HALF_MS;
      end else if (variant == lvl_pkg::V_ISAFE) begin
         hp = lvl_pkg::FAULT_HALF_MS;
      end else begin
         hp = lvl_pkg::BLINK_HALF_MS;
      end
      amt = 14'(HYST_STEP) * 14'(st.cfg.hyst);
   end

   always_comb begin
      nxt = st;
      nxt.tick = 1'b0;
      if (st.tdiv == 16'(TICK_CYCLES - 1)) begin
         nxt.tdiv = '0;
         nxt.tick = 1'b1;
      end else begin
         nxt.tdiv = st.tdiv + 16'h0001;
      end

      nxt.btn_q = btn_db;
      if (!btn_db) begin
         nxt.hold = '0;
      end else if (st.tick && st.hold != lvl_pkg::LONG_MS) begin
         nxt.hold = st.hold + 12'h001;
      end

      if (st.tick) begin
         if (st.sms >= slen - 12'h001) begin
            nxt.sms = '0;
            nxt.slot = gap ? 4'h0 : st.slot + 4'h1;
         end else begin
            nxt.sms = st.sms + 12'h001;
         end
         if (st.bcnt >= hp - 12'h001) begin
            nxt.bcnt = '0;
            nxt.blink = !st.blink;
         end else begin
            nxt.bcnt = st.bcnt + 12'h001;
         end
      end

      // switchpoint with hysteresis below it, widened by the chosen level
      if (st.wet_raw) begin
         if ({2'b00, sense.code} + amt < {2'b00, st.cfg.sp}) begin
            nxt.wet_raw = 1'b0;
         end
      end else if (sense.code >= st.cfg.sp) begin
         nxt.wet_raw = 1'b1;
      end

      if (st.tick) begin
         if (st.wet_raw == st.wet_dly) begin
            nxt.dcnt = '0;
         end else if (st.dcnt == lvl_pkg::DELAY_MS - 12'h001) begin
            nxt.wet_dly = st.wet_raw;
            nxt.dcnt = '0;
         end else begin
            nxt.dcnt = st.dcnt + 12'h001;
         end
      end

      if (!mag_db) begin
         nxt.tcnt = '0;
         nxt.test_on = 1'b0;
      end else if (st.tick && !st.test_on) begin
         if (st.tcnt == lvl_pkg::TEST_MS - 12'h001) begin
            nxt.test_on = 1'b1;
         end else begin
            nxt.tcnt = st.tcnt + 12'h001;
         end
      end

      unique case (st.state)
         lvl_pkg::ST_BOOT: begin
            // wait past the button settle time before sampling it
            if (st.tick) begin
               nxt.ms = st.ms + 12'h001;
            end
            if (st.ms == lvl_pkg::BOOT_MS) begin
               nxt.state = btn_db ? lvl_pkg::ST_HOLD : lvl_pkg::ST_RUN;
               nxt.ms = '0;
            end
         end
         lvl_pkg::ST_HOLD: begin
            if (st.tick && st.ms < lvl_pkg::HOLD_OFF_MS) begin
               nxt.ms = st.ms + 12'h001;
            end
            if (!btn_db) begin
               // release before the LED went out aborts to normal running
               nxt.state = (st.ms >= lvl_pkg::HOLD_OFF_MS) ? lvl_pkg::ST_MAIN
                                                            : lvl_pkg::ST_RUN;
               nxt.item = '0;
            end
         end
         lvl_pkg::ST_RUN: ;
         lvl_pkg::ST_MAIN: begin
            if (press && gap) begin
               nxt.state = lvl_pkg::ST_OPT;
               nxt.opt = st.item;
            end else if (st.tick && gap && st.sms >= slen - 12'h001) begin
               nxt.item = (st.item == imax) ? 2'h0 : st.item + 2'h1;
            end
         end
         lvl_pkg::ST_OPT: begin
            if (press) begin
               if (st.opt == lvl_pkg::OPT_SP) begin
                  nxt.cfg.sp = sense.code;
                  nxt.cfg.hyst = lvl_pkg::HYST_DEF;
                  nxt.cfg.lmode = lvl_pkg::LMODE_DEF;
                  nxt.state = lvl_pkg::ST_CONF;
               end else begin
                  nxt.state = lvl_pkg::ST_SUB;
                  nxt.item = '0;
               end
            end
         end
         lvl_pkg::ST_SUB: begin
            if (press && gap) begin
               if (st.opt == lvl_pkg::OPT_HYST) begin
                  nxt.cfg.hyst = st.item + 2'h1;
               end else begin
                  nxt.cfg.lmode = st.item[0];
               end
               nxt.state = lvl_pkg::ST_CONF;
            end else if (st.tick && gap && st.sms >= slen - 12'h001) begin
               nxt.item = (st.item == imax) ? 2'h0 : st.item + 2'h1;
            end
         end
         lvl_pkg::ST_CONF: begin
            if (st.tick && gap && st.sms >= slen - 12'h001) begin
               nxt.state = lvl_pkg::ST_MAIN;
               nxt.item = '0;
            end
         end
         default: nxt.state = lvl_pkg::ST_BOOT;
      endcase
      if (nxt.state != st.state) begin
         nxt.slot = '0;
         nxt.sms = '0;
      end
      nxt.cfg.cal = !(nxt.state inside {lvl_pkg::ST_BOOT, lvl_pkg::ST_RUN});

      // output stays open while the menus are active
      nxt.out = (st.state == lvl_pkg::ST_RUN) ? (base ^ test_inv) : 1'b0;

      nxt.led = 1'b0;
      unique case (st.state)
         lvl_pkg::ST_HOLD: begin
            nxt.led = (st.ms >= lvl_pkg::HOLD_ON_MS) && (st.ms < lvl_pkg::HOLD_OFF_MS);
         end
         lvl_pkg::ST_RUN: begin
            unique case (variant)
               lvl_pkg::V_TWO_WIRE: begin
                  nxt.led = (st.cfg.lmode ? st.wet_dly : st.out) | st.blink;
               end
               lvl_pkg::V_DC3, lvl_pkg::V_SAFE: begin
                  if (sense.fault || test_inv) begin
                     nxt.led = st.blink;
                  end else begin
                     nxt.led = pbase ^ pulse;
                  end
               end
               lvl_pkg::V_ISAFE: nxt.led = st.out | st.blink;
            endcase
         end
         lvl_pkg::ST_MAIN, lvl_pkg::ST_OPT, lvl_pkg::ST_SUB, lvl_pkg::ST_CONF: begin
            nxt.led = pbase ^ pulse;
         end
         default: ;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st <= '0;
         st.state <= lvl_pkg::ST_BOOT;
         st.cfg.sp <= SP_DEFAULT;
         st.cfg.hyst <= lvl_pkg::HYST_DEF;
         st.cfg.lmode <= lvl_pkg::LMODE_DEF;
      end else begin
         st <= nxt;
      end
   end

   assign out_closed = st.out;
   assign led = st.led;
   assign settings = st.cfg;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   a_led_shows_on: assert property (
      (st.state == lvl_pkg::ST_RUN && variant == lvl_pkg::V_TWO_WIRE && !st.cfg.lmode
       && st.out) |=> st.led)
      else $error("led not steady while output closed");

   a_switch_delay: assert property (
      $changed(st.wet_dly) |-> ($past(st.dcnt) == lvl_pkg::DELAY_MS - 12'h001) && $past(st.tick))
      else $error("wet decision changed before delay expired");

   a_dry_on_close: assert property (
      (st.state == lvl_pkg::ST_RUN && variant == lvl_pkg::V_TWO_WIRE && nc_sel)
      |=> st.out == !$past(st.wet_dly))
      else $error("dry-on output wrong");

   a_wet_on_close: assert property (
      (st.state == lvl_pkg::ST_RUN && variant == lvl_pkg::V_TWO_WIRE && !nc_sel)
      |=> st.out == $past(st.wet_dly))
      else $error("wet-on output wrong");

   a_cal_entry_led: assert property (
      (st.state == lvl_pkg::ST_HOLD) |=> st.led == ($past(st.ms) >= lvl_pkg::HOLD_ON_MS
                                                    && $past(st.ms) < lvl_pkg::HOLD_OFF_MS))
      else $error("calibration entry led timing wrong");

   a_menu_gap_dark: assert property (
      (st.state == lvl_pkg::ST_MAIN && gap) |=> !st.led)
      else $error("led lit in main menu gap");

   a_sp_capture: assert property (
      (st.state == lvl_pkg::ST_OPT && st.opt == lvl_pkg::OPT_SP && press)
      |=> st.cfg.sp == $past(sense.code) && st.cfg.hyst == lvl_pkg::HYST_DEF
          && st.state == lvl_pkg::ST_CONF)
      else $error("switchpoint capture wrong");

   a_no_menu_exit: assert property (
      (st.state inside {lvl_pkg::ST_MAIN, lvl_pkg::ST_OPT, lvl_pkg::ST_SUB, lvl_pkg::ST_CONF})
      |=> st.state != lvl_pkg::ST_RUN)
      else $error("menu left without power cycle");

   a_safe_open: assert property (
      (st.state == lvl_pkg::ST_RUN && variant == lvl_pkg::V_SAFE
       && (st.wet_dly || sense.fault)) |=> !st.out)
      else $error("safety output not open");

   a_test_invert: assert property (
      (st.state == lvl_pkg::ST_RUN && variant == lvl_pkg::V_DC3 && st.test_on)
      |=> st.out != $past(base))
      else $error("test magnet did not invert output");
endmodule

// ==== lvl_operator.sv ====
// operator model: setup button, test magnet and the fork sense input
// assumes the bench calls its tasks from one process; inputs change on falling edges
`timescale 1ns/100ps
module lvl_operator #(
   parameter int TCK = 10
) (
   input wire logic clk, // system clock
   output logic btn_raw, // setup button, high while pressed
   output logic magnet_raw, // test magnet present
   output lvl_pkg::sense_t sense // fork code and fault flag
);
   initial begin
      btn_raw = 1'b0;
      magnet_raw = 1'b0;
      sense = '{code: 12'h700, fault: 1'b0};
   end

   // a held button across power-up is how calibration is asked for
   task automatic hold_btn(input logic v);
      @(negedge clk);
      btn_raw = v;
   endtask

   // kept well under the long-press time so it counts as brief
   task automatic press(input int ms);
      @(negedge clk);
      btn_raw = 1'b1;
      repeat (ms * TCK) @(negedge clk);
      btn_raw = 1'b0;
   endtask

   task automatic put_magnet(input logic v);
      @(negedge clk);
      magnet_raw = v;
   endtask

   task automatic put_sense(input logic [11:0] code, input logic flt);
      @(negedge clk);
      sense = '{code: code, fault: flt};
   endtask
endmodule

// ==== level_switch_ctl_tb.sv ====
// self-checking bench for the level switch control block
// assumes a 4-clock millisecond tick so that second-long figures stay short
`timescale 1ns/100ps
module level_switch_ctl_tb;
   localparam int TCK = 4;
   typedef struct packed {
      lvl_pkg::var_t v;
      logic nc;
      logic flt;
      logic wet;
      logic exp;
   } row_t;

   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic btn_raw;
   logic magnet_raw;
   logic nc_sel;
   lvl_pkg::var_t variant;
   lvl_pkg::sense_t sense;
   logic out_closed;
   logic led;
   lvl_pkg::settings_t settings;
   int err_total = 0;
   int comparisons = 0;
   int tog;
   int fall;
   logic cur_wet = 1'b0;
   row_t rows[12] = '{
      '{lvl_pkg::V_TWO_WIRE, 1'b1, 1'b0, 1'b0, 1'b1},
      '{lvl_pkg::V_TWO_WIRE, 1'b0, 1'b0, 1'b0, 1'b0},
      '{lvl_pkg::V_DC3, 1'b1, 1'b0, 1'b0, 1'b1},
      '{lvl_pkg::V_SAFE, 1'b0, 1'b0, 1'b0, 1'b1},
      '{lvl_pkg::V_SAFE, 1'b1, 1'b1, 1'b0, 1'b0},
      '{lvl_pkg::V_ISAFE, 1'b0, 1'b0, 1'b0, 1'b0},
      '{lvl_pkg::V_TWO_WIRE, 1'b0, 1'b0, 1'b1, 1'b1},
      '{lvl_pkg::V_TWO_WIRE, 1'b1, 1'b0, 1'b1, 1'b0},
      '{lvl_pkg::V_DC3, 1'b0, 1'b0, 1'b1, 1'b1},
      '{lvl_pkg::V_SAFE, 1'b0, 1'b0, 1'b1, 1'b0},
      '{lvl_pkg::V_ISAFE, 1'b1, 1'b0, 1'b1, 1'b0},
      '{lvl_pkg::V_ISAFE, 1'b0, 1'b0, 1'b1, 1'b1}
   };

   always #10 clk = ~clk;

   level_switch_ctl #(.TICK_CYCLES(TCK)) u_level_switch_ctl (
      .clk(clk),
      .rst_n(rst_n),
      .btn_raw(btn_raw),
      .magnet_raw(magnet_raw),
      .nc_sel(nc_sel),
      .variant(variant),
      .sense(sense),
      .out_closed(out_closed),
      .led(led),
      .settings(settings)
   );

   lvl_operator #(.TCK(TCK)) u_lvl_operator (
      .clk(clk),
      .btn_raw(btn_raw),
      .magnet_raw(magnet_raw),
      .sense(sense)
   );

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wait_ms(input int ms);
      repeat (ms * TCK) @(negedge clk);
   endtask

   // counts LED changes and falling edges over a window
   task automatic watch(input int ms);
      logic p;
      begin
         tog = 0;
         fall = 0;
         p = led;
         repeat (ms * TCK) begin
            @(negedge clk);
            if (led !== p) tog++;
            if (p === 1'b1 && led === 1'b0) fall++;
            p = led;
         end
      end
   endtask

   task automatic power_cycle();
      @(negedge clk);
      rst_n = 1'b0;
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
   endtask

   function automatic logic closed_for(lvl_pkg::var_t v, logic nc, logic flt, logic wet);
      if (v == lvl_pkg::V_SAFE) return !wet && !flt;
      return nc ? !wet : wet;
   endfunction

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial begin
      // the scenarios need about 19.5 s of ticks, some 78000 clocks
      repeat (90000) @(posedge clk);
      err_total++;
      summarize();
   end

   initial begin
      nc_sel = 1'b1;
      variant = lvl_pkg::V_TWO_WIRE;
      power_cycle();
      @(negedge clk);
      check("settings", settings, {12'h800, 2'h2, 1'b0, 1'b0});
      wait_ms(100);
      foreach (rows[i]) begin
         @(negedge clk);
         variant = rows[i].v;
         nc_sel = rows[i].nc;
         if (rows[i].wet !== cur_wet || rows[i].flt !== sense.fault) begin
            u_lvl_operator.put_sense(rows[i].wet ? 12'h900 : 12'h700, rows[i].flt);
         end
         if (rows[i].wet !== cur_wet) begin
            // the output must still hold its old level 950 ms into the delay
            watch(950);
            check("out held", out_closed, closed_for(rows[i].v, rows[i].nc, 1'b0, cur_wet));
            check("blink open", tog > 0, 1'b1);
            wait_ms(150);
            cur_wet = rows[i].wet;
         end else begin
            repeat (20) @(negedge clk);
         end
         check("out row", out_closed, rows[i].exp);
      end
      @(negedge clk);
      variant = lvl_pkg::V_TWO_WIRE;
      nc_sel = 1'b0;
      watch(300);
      check("steady closed", {tog > 0, led}, 2'b01);
      // test magnet on the three-wire part, dry, contact closed
      @(negedge clk);
      variant = lvl_pkg::V_DC3;
      nc_sel = 1'b1;
      u_lvl_operator.put_sense(12'h700, 1'b0);
      wait_ms(1100);
      // the window spans one whole pulse-and-gap period, whatever its phase
      watch(2700);
      check("dc3 pulses", tog >= 4, 1'b1);
      u_lvl_operator.put_magnet(1'b1);
      wait_ms(3900);
      check("magnet early", out_closed, 1'b1);
      wait_ms(200);
      check("magnet inverted", out_closed, 1'b0);
      watch(400);
      check("test flash", tog >= 2, 1'b1);
      u_lvl_operator.put_magnet(1'b0);
      wait_ms(100);
      check("magnet removed", out_closed, 1'b1);
      u_lvl_operator.put_sense(12'h700, 1'b1);
      watch(300);
      check("fault flash", {tog >= 3, out_closed}, 2'b11);
      // calibration: button held through power-up; only a new power-up leaves it
      u_lvl_operator.put_sense(12'h840, 1'b0);
      u_lvl_operator.hold_btn(1'b1);
      power_cycle();
      wait_ms(1500);
      check("hold lit", {led, settings.cal}, 2'b11);
      wait_ms(650);
      check("hold dark", led, 1'b0);
      wait_ms(50);
      u_lvl_operator.hold_btn(1'b0);
      watch(400);
      check("main one flash", 16'(tog), 16'h0002);
      u_lvl_operator.press(200);
      wait_ms(300);
      check("switchpoint screen", {led, out_closed, settings.cal}, 3'b101);
      u_lvl_operator.press(200);
      watch(700);
      check("confirm flashes", 16'(fall), 16'h0003);
      check("switchpoint", settings, {12'h840, 2'h2, 1'b0, 1'b1});
      // hysteresis level one: let item one flash, then press in its dark gap
      wait_ms(3300);
      u_lvl_operator.press(100);
      watch(600);
      check("hyst screen", 16'(tog), 16'h0003);
      u_lvl_operator.press(100);
      watch(400);
      check("level one flash", 16'(fall), 16'h0001);
      u_lvl_operator.press(100);
      watch(700);
      check("level confirm", 16'(fall), 16'h0003);
      check("hysteresis", settings, {12'h840, 2'h1, 1'b0, 1'b1});
      summarize();
   end
endmodule
